// File: verilog/program_flash_self_access.sv
// program flash self-access controller: word read, unlocked 32-word block erase
// with processor stall, and the second peripheral flag group with its interrupt.
// assumes one clock per instruction cycle, and a flash array answering a read in
// the same cycle as its read strobe.
// the oscillator-fail and comparator inputs are asynchronous and are synchronised here.
//
// Summary of operation
// - array is accessed in second cycle after trigger; that fetch is squashed.
// - read word lands in data registers next cycle and holds until replaced.
// - self erase always clears one 32-word block; no word or bulk erase.
// - erase block is address bits 15:5; bits 4:0 are ignored.
// - erase needs program-space select, write enable and erase select all set.
// - erase accepted only after 55h then AAh written to unlock port.
// - two setup cycles follow the write trigger, covered by two no-ops.
// - processor stalls for the 2 ms erase; clocks keep running.
// - execution resumes at third instruction after the control write.
// - done flag bit 4 sets on completion; software clears it.
// - flags set whatever their enables or the global enable say.
// - oscillator-fail flag bit 7 sets on oscillator failure; software clears.
// - comparator-change flag bit 6 sets on comparator change; software clears.
// - flag bits 5 and 3..0 read as zero.
// - write enable clears at reset, blocking writes until software sets it.
// - no nonvolatile write starts while the 72 ms power-up timer runs.
`timescale 1ns/1ns
module program_flash_self_access
	import nvm_self_pkg::*;
#(
	parameter int unsigned ERASE_CNT = nvm_self_pkg::ERASE_CYCLES,
	parameter int unsigned PWRUP_CNT = nvm_self_pkg::PWRUP_CYCLES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// register port
	input wire logic [nvm_self_pkg::ADDR_W-1:0] i_addr,
	input wire logic [nvm_self_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [nvm_self_pkg::DATA_W-1:0] o_rdata,
	// processor core
	output logic o_cpu_stall,
	output logic o_fetch_squash,
	// flash array
	output logic [nvm_self_pkg::PROG_ADDR_W-1:0] o_arr_addr,
	output logic o_arr_rd,
	input wire logic [nvm_self_pkg::PROG_DATA_W-1:0] i_arr_rdata,
	output logic o_arr_erase,
	output logic [nvm_self_pkg::BLOCK_W-1:0] o_arr_block,
	// event sources from other clock domains
	input wire logic i_osc_fail,
	input wire logic i_cmp_change,
	// interrupt
	output logic o_irq
);
	import nvm_self_pkg::*;

	typedef struct packed {
		seq_state_type fsm;
		unlock_state_type unlock;
		logic [DATA_W-1:0] addr_low;
		logic [DATA_W-1:0] addr_high;
		logic [DATA_W-1:0] data_low;
		logic [DATA_HIGH_W-1:0] data_high;
		logic psel;
		logic erase_sel;
		logic write_enable_gate;
		logic rd_trig;
		logic wr_trig;
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] enables;
		logic global_irq_enable;
		logic [DATA_W-1:0] rdata;
		logic osc_s1;
		logic osc_s2;
		logic osc_prev;
		logic cmp_s1;
		logic cmp_s2;
		logic cmp_prev;
	} state_type;

	state_type state;
	state_type next_state;

	timer_if erase_tmr ();
	timer_if pwrup_tmr ();

	interval_timer #(
		.CYCLES(ERASE_CNT),
		.BUSY_AT_RESET(1'b0)
	) erase_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.tmr(erase_tmr.timer)
	);

	// the power-up window is timed from the release of reset
	interval_timer #(
		.CYCLES(PWRUP_CNT),
		.BUSY_AT_RESET(1'b1)
	) pwrup_timer (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.tmr(pwrup_tmr.timer)
	);

	assign pwrup_tmr.start = 1'b0;

	// erase timer is started as the second setup cycle ends
	assign erase_tmr.start = state.fsm == ST_ER_SETUP2;

	logic wr_ctl;
	logic wr_unlock;
	logic erase_ok;
	logic osc_event;
	logic cmp_event;
	logic [DATA_W-1:0] ctl_view;
	logic [DATA_W-1:0] flag_events;
	logic [DATA_W-1:0] flag_base;
	logic wr_flags;
	logic rd_flags;
	logic [DATA_W-1:0] pending;

	// bus decode and the erase gate, shared by the next-state logic below
	always_comb begin
		wr_ctl = i_wr && i_addr == OFS_CONTROL;
		wr_unlock = i_wr && i_addr == OFS_UNLOCK;
		wr_flags = i_wr && i_addr == OFS_FLAGS;
		rd_flags = i_rd && i_addr == OFS_FLAGS;

		// bits of the written value govern the erase, so one write may select and trigger
		erase_ok = i_wdata[CTL_PSEL] && i_wdata[CTL_WRITE_ENABLE_GATE] && i_wdata[CTL_ERASE];
		// write_enable_gate comes from the register, so a stray write cannot enable and fire at once
		erase_ok = erase_ok && state.write_enable_gate;
		erase_ok = erase_ok && state.unlock == UL_BOTH;
		erase_ok = erase_ok && !pwrup_tmr.busy;

		osc_event = state.osc_s2 && !state.osc_prev;
		cmp_event = state.cmp_s2 != state.cmp_prev;

		// control register as software sees it
		ctl_view = RST_BYTE;
		ctl_view[CTL_PSEL] = state.psel;
		ctl_view[CTL_ERASE] = state.erase_sel;
		ctl_view[CTL_WRITE_ENABLE_GATE] = state.write_enable_gate;
		ctl_view[CTL_WR] = state.wr_trig;
		ctl_view[CTL_RD] = state.rd_trig;
		// no write is ever cut short here, so the error bit always reads clear
		ctl_view[CTL_WRERR] = 1'b0;

		// one-cycle set requests for the flag group
		flag_events = RST_BYTE;
		flag_events[FLG_OSC] = osc_event;
		flag_events[FLG_CMP] = cmp_event;
		flag_events[FLG_DONE] = erase_tmr.done;
		flag_base = state.flags;
		if (wr_flags) begin
			flag_base = i_wdata;
		end else if (rd_flags) begin
			flag_base = RST_BYTE;
		end
		pending = state.flags & state.enables;
	end

	always_comb begin
		next_state = state;

		// two-stage synchronisers, then change detection on the second stage
		next_state.osc_s1 = i_osc_fail;
		next_state.osc_s2 = state.osc_s1;
		next_state.osc_prev = state.osc_s2;
		next_state.cmp_s1 = i_cmp_change;
		next_state.cmp_s2 = state.cmp_s1;
		next_state.cmp_prev = state.cmp_s2;

		// events win over a same-cycle clear, enables never gate them
		next_state.flags = (flag_base | flag_events) & FLG_IMPL_MASK;

		// unlock tracker: 55h then AAh on back-to-back cycles
		next_state.unlock = UL_NONE;
		if (wr_unlock && i_wdata == UNLOCK_FIRST) begin
			next_state.unlock = UL_FIRST;
		end else if (wr_unlock && i_wdata == UNLOCK_SECOND && state.unlock == UL_FIRST) begin
			next_state.unlock = UL_BOTH;
		end

		// plain register writes
		if (i_wr) begin
			unique case (i_addr)
				OFS_ADDR_LOW: begin
					next_state.addr_low = i_wdata;
				end
				OFS_ADDR_HIGH: begin
					next_state.addr_high = i_wdata;
				end
				OFS_DATA_LOW: begin
					next_state.data_low = i_wdata;
				end
				OFS_DATA_HIGH: begin
					next_state.data_high = i_wdata[DATA_HIGH_W-1:0];
				end
				OFS_ENABLES: begin
					next_state.enables = i_wdata & FLG_IMPL_MASK;
				end
				OFS_IRQ_CTRL: begin
					next_state.global_irq_enable = i_wdata[IC_GIE];
				end
				default: begin
				end
			endcase
		end

		// control writes are ignored while the sequencer is busy
		if (wr_ctl && state.fsm == ST_IDLE) begin
			next_state.psel = i_wdata[CTL_PSEL];
			next_state.erase_sel = i_wdata[CTL_ERASE];
			next_state.write_enable_gate = i_wdata[CTL_WRITE_ENABLE_GATE];
			if (i_wdata[CTL_WR] && erase_ok) begin
				next_state.wr_trig = 1'b1;
				next_state.fsm = ST_ER_SETUP1;
			end else if (i_wdata[CTL_RD] && i_wdata[CTL_PSEL]) begin
				// a read trigger without program space selects data memory, not handled here
				next_state.rd_trig = 1'b1;
				next_state.fsm = ST_RD_WAIT;
			end
		end

		// sequencer: both paths walk back to idle by themselves
		unique case (state.fsm)
			ST_IDLE: begin
				// waits for a trigger taken by the control write above
			end
			ST_RD_WAIT: begin
				// the fetch of this cycle still executes
				next_state.fsm = ST_RD_ACCESS;
			end
			ST_RD_ACCESS: begin
				// array answers in this cycle; latched so it is visible the next
				next_state.data_low = i_arr_rdata[DATA_W-1:0];
				next_state.data_high = i_arr_rdata[PROG_DATA_W-1:DATA_W];
				next_state.rd_trig = 1'b0;
				next_state.fsm = ST_IDLE;
			end
			ST_ER_SETUP1: begin
				// first of the two no-ops that follow the trigger
				next_state.fsm = ST_ER_SETUP2;
			end
			ST_ER_SETUP2: begin
				// second no-op; the erase timer loads at the end of it
				next_state.fsm = ST_ER_RUN;
			end
			ST_ER_RUN: begin
				// the done flag is requested in this same last cycle
				if (erase_tmr.done) begin
					next_state.wr_trig = 1'b0;
					next_state.fsm = ST_IDLE;
				end
			end
			default: begin
				next_state.fsm = ST_IDLE;
			end
		endcase

		// read data for the cycle after the strobe
		next_state.rdata = RST_BYTE;
		if (i_rd) begin
			unique case (i_addr)
				OFS_FLAGS: begin
					next_state.rdata = state.flags;
				end
				OFS_ENABLES: begin
					next_state.rdata = state.enables;
				end
				OFS_IRQ_CTRL: begin
					next_state.rdata[IC_GIE] = state.global_irq_enable;
				end
				OFS_ADDR_LOW: begin
					next_state.rdata = state.addr_low;
				end
				OFS_ADDR_HIGH: begin
					next_state.rdata = state.addr_high;
				end
				OFS_DATA_LOW: begin
					next_state.rdata = state.data_low;
				end
				OFS_DATA_HIGH: begin
					next_state.rdata = {2'h0, state.data_high};
				end
				OFS_CONTROL: begin
					next_state.rdata = ctl_view;
				end
				// the unlock port is not a storage location
				default: begin
					next_state.rdata = RST_BYTE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			// every register clears, the address and data holding pair included
			state.fsm <= ST_IDLE;
			state.unlock <= UL_NONE;
			state.addr_low <= RST_BYTE;
			state.addr_high <= RST_BYTE;
			state.data_low <= RST_BYTE;
			state.data_high <= RST_DATA_HIGH;
			state.psel <= 1'b0;
			state.erase_sel <= 1'b0;
			state.write_enable_gate <= 1'b0;
			state.rd_trig <= 1'b0;
			state.wr_trig <= 1'b0;
			state.flags <= RST_BYTE;
			state.enables <= RST_BYTE;
			state.global_irq_enable <= 1'b0;
			state.rdata <= RST_BYTE;
			state.osc_s1 <= 1'b0;
			state.osc_s2 <= 1'b0;
			state.osc_prev <= 1'b0;
			state.cmp_s1 <= 1'b0;
			state.cmp_s2 <= 1'b0;
			state.cmp_prev <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// outputs
	assign o_rdata = state.rdata;
	// stall covers only the erase itself; the two setup cycles execute no-ops
	assign o_cpu_stall = state.fsm == ST_ER_RUN;
	assign o_fetch_squash = state.fsm == ST_RD_ACCESS;
	assign o_arr_addr = {state.addr_high, state.addr_low};
	assign o_arr_rd = state.fsm == ST_RD_ACCESS;
	assign o_arr_erase = state.fsm == ST_ER_RUN;
	assign o_arr_block = o_arr_addr[PROG_ADDR_W-1:BLOCK_LSB];
	// a level, not a pulse: it falls once a flag read clears the pending bits
	assign o_irq = state.global_irq_enable && pending != RST_BYTE;
endmodule

// File: verilog/nvm_self_pkg.sv
// package for the program flash self-access block: register map, field positions,
// reset values, sequencer states and timing constants.
// assumes a 100 MHz instruction clock, one clock per instruction cycle.
package nvm_self_pkg;

	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;

	// register byte offsets on the register port
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 9'h00D;
	localparam logic [ADDR_W-1:0] OFS_ENABLES = 9'h08D;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 9'h08B;
	localparam logic [ADDR_W-1:0] OFS_DATA_LOW = 9'h10C;
	localparam logic [ADDR_W-1:0] OFS_ADDR_LOW = 9'h10D;
	localparam logic [ADDR_W-1:0] OFS_DATA_HIGH = 9'h10E;
	localparam logic [ADDR_W-1:0] OFS_ADDR_HIGH = 9'h10F;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 9'h18C;
	localparam logic [ADDR_W-1:0] OFS_UNLOCK = 9'h18D;

	// nvm_control fields
	localparam int CTL_PSEL = 7;
	localparam int CTL_ERASE = 4;
	localparam int CTL_WRERR = 3;
	localparam int CTL_WRITE_ENABLE_GATE = 2;
	localparam int CTL_WR = 1;
	localparam int CTL_RD = 0;

	// flag and enable fields (same layout in both registers)
	localparam int FLG_OSC = 7;
	localparam int FLG_CMP = 6;
	localparam int FLG_DONE = 4;
	localparam logic [DATA_W-1:0] FLG_IMPL_MASK = 8'hD0;

	// interrupt_control fields
	localparam int IC_GIE = 7;

	// widths of the array side
	localparam int PROG_ADDR_W = 16;
	localparam int PROG_DATA_W = 14;
	localparam int DATA_HIGH_W = 6;
	localparam int BLOCK_LSB = 5;
	localparam int BLOCK_W = PROG_ADDR_W - BLOCK_LSB;

	// unlock values
	localparam logic [DATA_W-1:0] UNLOCK_FIRST = 8'h55;
	localparam logic [DATA_W-1:0] UNLOCK_SECOND = 8'hAA;

	// reset values
	localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
	localparam logic [DATA_HIGH_W-1:0] RST_DATA_HIGH = 6'h00;

	// timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned ERASE_TIME_US = 2000;
	localparam int unsigned PWRUP_TIME_MS = 72;
	localparam int unsigned US_PER_MS = 1000;
	localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned PWRUP_CYCLES = PWRUP_TIME_MS * US_PER_MS * CLK_MHZ;
	localparam int CNT_W = 32;

	// sequencer states, gray coded along read and erase paths except the steps back to idle
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_RD_WAIT = 3'h1,
		ST_RD_ACCESS = 3'h3,
		ST_ER_SETUP1 = 3'h2,
		ST_ER_SETUP2 = 3'h6,
		ST_ER_RUN = 3'h7
	} seq_state_type;

	// unlock tracker
	typedef enum logic [1:0] {
		UL_NONE = 2'h0,
		UL_FIRST = 2'h1,
		UL_BOTH = 2'h3
	} unlock_state_type;

endpackage

// File: verilog/timer_if.sv
// interface between the sequencer and its interval timers.
// assumes owner and timer share i_clk.
`timescale 1ns/1ns
interface timer_if;
	logic start;
	logic busy;
	logic done;

	modport owner (output start, input busy, input done);
	modport timer (input start, output busy, output done);
endinterface

// File: verilog/interval_timer.sv
// down-counting interval timer: busy for CYCLES clocks after start, done on the last.
// assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ns
module interval_timer
	import nvm_self_pkg::*;
#(
	parameter int unsigned CYCLES = 16,
	parameter bit BUSY_AT_RESET = 1'b0
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// control
	timer_if.timer tmr
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
	} state_type;

	localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES);
	localparam logic [CNT_W-1:0] ONE = 32'h00000001;
	localparam logic [CNT_W-1:0] ZERO = 32'h00000000;

	state_type state;
	state_type next_state;

	always_comb begin
		next_state = state;
		if (tmr.start) begin
			next_state.count = LOAD;
		end else if (state.count != ZERO) begin
			next_state.count = state.count - ONE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			// a timer busy at reset covers the power-up window
			state.count <= BUSY_AT_RESET ? LOAD : ZERO;
		end else begin
			state <= next_state;
		end
	end

	assign tmr.busy = state.count != ZERO;
	assign tmr.done = state.count == ONE;
endmodule

// File: verification/nvm_self_chk.sv
// port checker for the program flash self-access block, bound to its top module.
// assumes one clock and a synchronous active-high reset held for at least two edges.
`timescale 1ns/1ns
module nvm_self_chk
	import nvm_self_pkg::*;
#(
	parameter int unsigned ERASE_CNT = 20
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// register port
	input wire logic [nvm_self_pkg::ADDR_W-1:0] i_addr,
	input wire logic [nvm_self_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [nvm_self_pkg::DATA_W-1:0] o_rdata,
	// core and array
	input wire logic o_cpu_stall,
	input wire logic o_fetch_squash,
	input wire logic [nvm_self_pkg::PROG_ADDR_W-1:0] o_arr_addr,
	input wire logic o_arr_rd,
	input wire logic o_arr_erase,
	input wire logic [nvm_self_pkg::BLOCK_W-1:0] o_arr_block
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic [31:0] run_len;
	logic ctl_wr, ctl_go, ul_first, ul_second;
	assign ctl_wr = i_wr && i_addr == OFS_CONTROL;
	assign ctl_go = ctl_wr && i_wdata[CTL_WR];
	assign ul_first = i_wr && i_addr == OFS_UNLOCK && i_wdata == UNLOCK_FIRST;
	assign ul_second = i_wr && i_addr == OFS_UNLOCK && i_wdata == UNLOCK_SECOND;
	// run length keeps its count in the cycle the erase drops, so it can be judged there
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			run_len <= 32'h0;
		end else begin
			run_len <= o_arr_erase ? run_len + 32'h1 : 32'h0;
		end
	end
	// a trigger that also sets the write bit may start an erase instead of a read
	read_launch_a: assert property (
		ctl_wr && i_wdata[CTL_PSEL] && i_wdata[CTL_RD] && !i_wdata[CTL_WR] && !o_cpu_stall
		|=> !o_arr_rd ##1 o_arr_rd) else $error("array read not in second cycle");
	no_psel_read_a: assert property (
		ctl_wr && !i_wdata[CTL_PSEL] |=> !o_arr_rd [*2])
		else $error("array read without program select");
	squash_pair_a: assert property (o_fetch_squash == o_arr_rd)
		else $error("squash and array read differ");
	rd_single_a: assert property (o_arr_rd |=> !o_arr_rd) else $error("array read too long");
	flag_pad_a: assert property (
		i_rd && i_addr == OFS_FLAGS |=> (o_rdata & ~FLG_IMPL_MASK) == 8'h00)
		else $error("unused flag bits set");
	block_sel_a: assert property (o_arr_block == o_arr_addr[15:BLOCK_LSB])
		else $error("erase block not upper address");
	stall_erase_a: assert property (o_arr_erase == o_cpu_stall)
		else $error("stall and erase differ");
	erase_len_a: assert property ($fell(o_arr_erase) |-> run_len == ERASE_CNT)
		else $error("erase length wrong");
	unlock_first_a: assert property (
		$rose(o_arr_erase) |-> $past(ctl_go, 3) && $past(ul_second, 4) && $past(ul_first, 5))
		else $error("erase without unlock");
	cover property (o_arr_rd);
	cover property ($rose(o_arr_erase));
	cover property (i_rd && i_addr == OFS_FLAGS ##1 o_rdata != 8'h00);
endmodule

bind program_flash_self_access nvm_self_chk #(.ERASE_CNT(ERASE_CNT)) chk (
	.i_clk(i_clk),
	.i_srst(i_srst),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_wr(i_wr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_cpu_stall(o_cpu_stall),
	.o_fetch_squash(o_fetch_squash),
	.o_arr_addr(o_arr_addr),
	.o_arr_rd(o_arr_rd),
	.o_arr_erase(o_arr_erase),
	.o_arr_block(o_arr_block)
);

// File: verification/flash_array_model.sv
// behavioural flash array: answers a read in its strobe cycle and records erased blocks.
// assumes the controller samples the word only while the read strobe is high.
`timescale 1ns/1ns
module flash_array_model
	import nvm_self_pkg::*;
(
	// clock
	input wire logic i_clk,
	// array port
	input wire logic [nvm_self_pkg::PROG_ADDR_W-1:0] i_arr_addr,
	input wire logic i_arr_rd,
	input wire logic i_arr_erase,
	input wire logic [nvm_self_pkg::BLOCK_W-1:0] i_arr_block,
	output logic [nvm_self_pkg::PROG_DATA_W-1:0] o_arr_rdata,
	// seen by the bench
	output logic [nvm_self_pkg::BLOCK_W-1:0] o_erased_block
);
	logic [PROG_DATA_W-1:0] last = 14'h0000;
	// off the strobe the word flips every cycle, so a late sample cannot pass by luck
	always_comb begin
		if (i_arr_rd) begin
			o_arr_rdata = i_arr_addr[PROG_DATA_W-1:0] ^ 14'h2A5A;
		end else begin
			o_arr_rdata = ~last;
		end
	end
	always_ff @(posedge i_clk) begin
		last <= o_arr_rdata;
		if (i_arr_erase) begin
			o_erased_block <= i_arr_block;
		end
	end
endmodule

// File: verification/program_flash_self_access_tb_top.sv
// self-checking bench for the program flash self-access block.
// assumes shortened erase and power-up counts; the array model sits on the far side.
`timescale 1ns/1ns
module program_flash_self_access_tb_top;
	import nvm_self_pkg::*;
	localparam int unsigned N_ERASE = 20;
	localparam int unsigned N_PWRUP = 10;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] exp;
	} row_type;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [ADDR_W-1:0] i_addr = 9'h000;
	logic [DATA_W-1:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_osc_fail = 1'b0;
	logic i_cmp_change = 1'b0;
	logic [DATA_W-1:0] o_rdata;
	logic o_cpu_stall, o_fetch_squash, o_arr_rd, o_arr_erase, o_irq;
	logic [PROG_ADDR_W-1:0] o_arr_addr;
	logic [PROG_DATA_W-1:0] i_arr_rdata, w;
	logic [BLOCK_W-1:0] o_arr_block, erased;
	int fail_count = 0;
	int n_compared = 0;
	int cycles = 0;
	int stall_len;
	row_type rows [8] = '{
		'{OFS_ADDR_LOW, 8'hA5, 8'hA5}, '{OFS_ADDR_HIGH, 8'h5A, 8'h5A},
		'{OFS_DATA_LOW, 8'h3C, 8'h3C}, '{OFS_DATA_HIGH, 8'hFF, 8'h3F},
		'{OFS_FLAGS, 8'hFF, 8'hD0}, '{OFS_ENABLES, 8'hFF, 8'hD0},
		'{9'h1FF, 8'hFF, 8'h00}, '{OFS_IRQ_CTRL, 8'h80, 8'h80}};
	// first, second unlock byte, gap cycles, control value
	logic [31:0] bad [5] = '{32'h55AA0197, 32'hAA550097, 32'h55AA0093, 32'h55AA0017,
		32'h55AA0087};
	logic [15:0] raddr [2] = '{16'h8001, 16'h7FFE};

	program_flash_self_access #(.ERASE_CNT(N_ERASE), .PWRUP_CNT(N_PWRUP)) DUT (
		.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_stall(o_cpu_stall),
		.o_fetch_squash(o_fetch_squash), .o_arr_addr(o_arr_addr), .o_arr_rd(o_arr_rd),
		.i_arr_rdata(i_arr_rdata), .o_arr_erase(o_arr_erase), .o_arr_block(o_arr_block),
		.i_osc_fail(i_osc_fail), .i_cmp_change(i_cmp_change), .o_irq(o_irq));
	flash_array_model array (.i_clk(i_clk), .i_arr_addr(o_arr_addr), .i_arr_rd(o_arr_rd),
		.i_arr_erase(o_arr_erase), .i_arr_block(o_arr_block), .o_arr_rdata(i_arr_rdata),
		.o_erased_block(erased));

	initial begin
		forever #5 i_clk = ~i_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		i_wr <= wr;
		i_rd <= rd;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
	endtask

	task automatic idle(input int n);
		repeat (n) bus(1'b0, 1'b0, 9'h000, 8'h00);
	endtask

	// read data stand only in the cycle after the strobe, so look one step past the edge
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		i_rd <= 1'b0;
		#1;
		check(o_rdata, e);
	endtask

	task automatic erase_try(input logic [DATA_W-1:0] f, input logic [DATA_W-1:0] s,
		input int gap, input logic [DATA_W-1:0] ctl);
		bus(1'b1, 1'b0, OFS_UNLOCK, f);
		idle(gap);
		bus(1'b1, 1'b0, OFS_UNLOCK, s);
		bus(1'b1, 1'b0, OFS_CONTROL, ctl);
		idle(1);
	endtask

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles > 3000) begin
			fail_count++;
			stop_test();
		end
	end

	initial begin
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		rdc(OFS_CONTROL, 8'h00);
		bus(1'b1, 1'b0, OFS_CONTROL, 8'h84);
		erase_try(8'h55, 8'hAA, 0, 8'h97);
		idle(2);
		#1;
		check(o_cpu_stall, 1'b0);
		idle(N_PWRUP);
		$display("reset and power-up done");
		foreach (rows[k]) begin
			bus(1'b1, 1'b0, rows[k].addr, rows[k].wdata);
			rdc(rows[k].addr, rows[k].exp);
		end
		bus(1'b1, 1'b0, OFS_FLAGS, 8'h10);
		idle(2);
		#1;
		check(o_irq, 1'b1);
		rdc(OFS_FLAGS, 8'h10);
		idle(2);
		#1;
		check(o_irq, 1'b0);
		$display("register table done");
		w = 14'h3F3C;
		foreach (raddr[k]) begin
			bus(1'b1, 1'b0, OFS_ADDR_HIGH, raddr[k][15:8]);
			bus(1'b1, 1'b0, OFS_ADDR_LOW, raddr[k][7:0]);
			bus(1'b1, 1'b0, OFS_CONTROL, 8'h01);
			idle(3);
			rdc(OFS_DATA_LOW, w[7:0]);
			bus(1'b1, 1'b0, OFS_CONTROL, 8'h81);
			idle(1);
			#1;
			check(o_fetch_squash, 1'b1);
			idle(2);
			w = raddr[k][13:0] ^ 14'h2A5A;
			rdc(OFS_DATA_LOW, w[7:0]);
			rdc(OFS_DATA_HIGH, {2'b00, w[13:8]});
		end
		$display("program read done");
		foreach (bad[k]) begin
			// write_enable_gate is set afresh so that each try is refused for one reason only
			bus(1'b1, 1'b0, OFS_CONTROL, 8'h84);
			erase_try(bad[k][31:24], bad[k][23:16], int'(bad[k][15:8]), bad[k][7:0]);
			idle(3);
			#1;
			check(o_cpu_stall, 1'b0);
		end
		bus(1'b1, 1'b0, OFS_CONTROL, 8'h80);
		erase_try(8'h55, 8'hAA, 0, 8'h97);
		idle(3);
		#1;
		check(o_cpu_stall, 1'b0);
		$display("refused erase done");
		bus(1'b1, 1'b0, OFS_ADDR_HIGH, 8'h12);
		bus(1'b1, 1'b0, OFS_ADDR_LOW, 8'h3F);
		bus(1'b1, 1'b0, OFS_CONTROL, 8'h94);
		bus(1'b1, 1'b0, OFS_ENABLES, 8'h10);
		erase_try(8'h55, 8'hAA, 0, 8'h97);
		idle(1);
		#1;
		check(o_cpu_stall, 1'b1);
		stall_len = 0;
		while (o_cpu_stall === 1'b1 && stall_len < 100) begin
			@(posedge i_clk);
			#1;
			stall_len++;
		end
		check(16'(stall_len), 16'(N_ERASE));
		check(erased, 11'h091);
		check(o_irq, 1'b1);
		rdc(OFS_FLAGS, 8'h10);
		$display("block erase done");
		bus(1'b1, 1'b0, OFS_ENABLES, 8'h00);
		i_osc_fail <= 1'b1;
		idle(6);
		#1;
		check(o_irq, 1'b0);
		bus(1'b1, 1'b0, OFS_ENABLES, 8'h80);
		idle(2);
		#1;
		check(o_irq, 1'b1);
		rdc(OFS_FLAGS, 8'h80);
		rdc(OFS_FLAGS, 8'h00);
		i_cmp_change <= 1'b1;
		idle(6);
		rdc(OFS_FLAGS, 8'h40);
		i_cmp_change <= 1'b0;
		idle(6);
		rdc(OFS_FLAGS, 8'h40);
		$display("event flags done");
		stop_test();
	end
endmodule
